// [common/ilc_pkg.sv]
// shared constants and helpers for the interpolator lane-zero block
package ilc_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFS_LOOK0 = 12'h0A0;
   localparam logic [11:0] OFS_LOOK1 = 12'h0A4;
   localparam logic [11:0] OFS_LOOKF = 12'h0A8;
   localparam logic [11:0] OFS_CTRL0 = 12'h0AC;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_WR_MASK = 32'h003F_FFFF;
   localparam logic [31:0] CTRL_WR_MASK_NB = 32'h001F_FFFF;
   // ------------------------------------------------------------
   // control field positions
   // ------------------------------------------------------------
   localparam int SHIFT_LO = 0;
   localparam int MLSB_LO = 5;
   localparam int MMSB_LO = 10;
   localparam int SIGNED_BIT = 15;
   localparam int XIN_BIT = 16;
   localparam int XRES_BIT = 17;
   localparam int RAW_BIT = 18;
   localparam int FORCE_LO = 19;
   localparam int INTERPOLATE_MODE_BIT = 21;
   localparam int EXC0_BIT = 23;
   localparam int EXC1_BIT = 24;
   localparam int EXCA_BIT = 25;
   localparam int FORCE_DST_LO = 28;
   localparam int ALPHA_W = 8;
   localparam int RST_STAGES = 2;
   localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;

   // five-bit field at a position
   function automatic logic [4:0] ilc_fld5(input logic [31:0] c,
                                           input int lo);
      ilc_fld5 = c[lo+:5];
   endfunction

   // force field ORed into the top address bits of a bus result
   function automatic logic [31:0] ilc_force(input logic [31:0] v,
                                             input logic [31:0] c);
      logic [31:0] f;
      f = '0;
      f[FORCE_DST_LO+:2] = c[FORCE_LO+:2];
      ilc_force = v | f;
   endfunction
endpackage

// [hdl/ilc_lane_path.sv]
// shift, mask and sign-extend path of one lane
`timescale 1ns/10ps
module ilc_lane_path
   import ilc_pkg::*;
(
   // selected accumulator and lane control
   input wire logic [31:0] acc_in,
   input wire logic [31:0] ctrl,
   // results
   output logic [31:0] sm,
   output logic [31:0] sm_ext,
   output logic excess
);
   logic [31:0] shifted;
   logic [31:0] keep_lo;
   logic [31:0] keep_hi;
   logic [4:0] msb;
   logic sign;

   always_comb begin
      msb = ilc_fld5(ctrl, MMSB_LO);
      shifted = acc_in >> ilc_fld5(ctrl, SHIFT_LO);
      keep_lo = ALL_ONES << ilc_fld5(ctrl, MLSB_LO);
      keep_hi = ALL_ONES >> (5'd31 - msb);
      sm = shifted & keep_lo & keep_hi;
      excess = |(shifted & ~keep_hi);
      sign = sm[msb];
      sm_ext = sm;
      if (ctrl[SIGNED_BIT] && sign) begin
         sm_ext = sm | ~keep_hi;
      end
   end
endmodule // ilc_lane_path

// [hdl/ilc_interpolate_mode.sv]
// linear interpolate_mode between the first and second offsets
`timescale 1ns/10ps
module ilc_interpolate_mode
   import ilc_pkg::*;
(
   // operands
   input wire logic [31:0] base_a,
   input wire logic [31:0] base_b,
   input wire logic [ALPHA_W-1:0] alpha,
   input wire logic is_signed,
   // result
   output logic [31:0] result
);
   logic signed [32:0] diff;
   logic signed [41:0] prod;

   always_comb begin
      if (is_signed) begin
         diff = $signed({base_b[31], base_b}) - $signed({base_a[31], base_a});
      end else begin
         diff = $signed({1'b0, base_b}) - $signed({1'b0, base_a});
      end
      prod = diff * $signed({1'b0, alpha});
      result = base_a + prod[39:8];
   end
endmodule // ilc_interpolate_mode

// [hdl/ilc_top.sv]
// interpolator lane zero: datapath, control register and look reads
//
// What this block does
// - reading first-channel look returns first_channel result, changes nothing
// - reading second-channel look returns second_channel result, changes nothing
// - reading combined look returns combined result, changes nothing
// - control bit 23 shows masked-off high bits set in accumulator 0
// - control bit 24 shows masked-off high bits set in accumulator 1
// - control bit 25 is the OR of bits 23 and 24
// - interpolate bit 21 exists only in the first instance
// - interpolate mode makes second_channel a interpolate_mode of offsets by 8-bit weight
// - interpolate mode makes first_channel only the low 8 bits of second_channel value
// - interpolate mode makes combined result third offset plus first_channel
// - second_channel sign flag picks signed or unsigned interpolate_mode
// - bits 20:19 ORed into bus result bits 29:28 only
// - bit 18 bypasses shift and mask for first_channel result only
// - bit 17 loads accumulator 0 with second_channel result on advance
// - bit 16 feeds accumulator 1 into first_channel path, also in bypass
// - bit 15 sign-extends first_channel value before the offset add
// - mask passes bits from low index to high index inclusive
// - accumulator is logically right-shifted before masking
// - advancing read writes lane results back to both accumulators
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
module ilc_top
   import ilc_pkg::*;
#(
   parameter bit FIRST_INSTANCE = 1'b1
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register port
   input wire logic [ilc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // shared interpolator state
   input wire logic [31:0] first_accumulator,
   input wire logic [31:0] second_accumulator,
   input wire logic [31:0] first_offset,
   input wire logic [31:0] second_offset,
   input wire logic [31:0] third_offset,
   input wire logic [31:0] second_channel_control,
   // advancing read and accumulator write-back
   input wire logic advance_read,
   output logic wb_valid,
   output logic [31:0] first_accumulator_load,
   output logic [31:0] second_accumulator_load
);
   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic [RST_STAGES-1:0] rst_pipe_reg;
   logic rst_sync_n;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_pipe_reg <= '0;
      end else begin
         rst_pipe_reg <= {rst_pipe_reg[RST_STAGES-2:0], 1'b1};
      end
   end
   assign rst_sync_n = rst_pipe_reg[RST_STAGES-1];

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic [31:0] ctrl1;
   logic interpolate_mode;

   always_comb begin
      ctrl_next = ctrl_reg;
      if (reg_wr && reg_addr == OFS_CTRL0) begin
         if (FIRST_INSTANCE) begin
            ctrl_next = reg_wdata & CTRL_WR_MASK;
         end else begin
            ctrl_next = reg_wdata & CTRL_WR_MASK_NB;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ctrl_reg <= CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   assign ctrl1 = second_channel_control;
   assign interpolate_mode = FIRST_INSTANCE && ctrl_reg[INTERPOLATE_MODE_BIT];

   // ------------------------------------------------------------
   // lane datapaths
   // ------------------------------------------------------------
   logic [31:0] acc0_sel;
   logic [31:0] acc1_sel;
   logic [31:0] sm0, sm0_ext, sm1, sm1_ext;
   logic exc0, exc1;
   logic [31:0] interpolate_mode_res;

   assign acc0_sel = ctrl_reg[XIN_BIT] ? second_accumulator
                                        : first_accumulator;
   assign acc1_sel = ctrl1[XIN_BIT] ? first_accumulator
                                     : second_accumulator;

   ilc_lane_path u_first_channel (
      .acc_in(acc0_sel),
      .ctrl(ctrl_reg),
      .sm(sm0),
      .sm_ext(sm0_ext),
      .excess(exc0)
   );

   ilc_lane_path u_second_channel (
      .acc_in(acc1_sel),
      .ctrl(ctrl1),
      .sm(sm1),
      .sm_ext(sm1_ext),
      .excess(exc1)
   );

   ilc_interpolate_mode u_interpolate_mode (
      .base_a(first_offset),
      .base_b(second_offset),
      .alpha(sm1[ALPHA_W-1:0]),
      .is_signed(ctrl1[SIGNED_BIT]),
      .result(interpolate_mode_res)
   );

   // ------------------------------------------------------------
   // lane and combined results
   // ------------------------------------------------------------
   logic [31:0] first_channel_res, second_channel_res, full_res;
   logic [31:0] first_channel_bus, second_channel_bus;
   logic [31:0] ctrl_view;

   always_comb begin
      if (interpolate_mode) begin
         first_channel_res = {24'h00_0000, sm1[ALPHA_W-1:0]};
      end else if (ctrl_reg[RAW_BIT]) begin
         first_channel_res = first_offset + acc0_sel;
      end else begin
         first_channel_res = first_offset + sm0_ext;
      end
      if (interpolate_mode) begin
         second_channel_res = interpolate_mode_res;
      end else if (ctrl1[RAW_BIT]) begin
         second_channel_res = second_offset + acc1_sel;
      end else begin
         second_channel_res = second_offset + sm1_ext;
      end
      if (interpolate_mode) begin
         full_res = third_offset + sm0_ext;
      end else begin
         full_res = third_offset + sm0_ext + sm1_ext;
      end
   end

   assign first_channel_bus = ilc_force(first_channel_res, ctrl_reg);
   assign second_channel_bus = ilc_force(second_channel_res, ctrl1);

   always_comb begin
      ctrl_view = ctrl_reg;
      ctrl_view[EXC0_BIT] = exc0;
      ctrl_view[EXC1_BIT] = exc1;
      ctrl_view[EXCA_BIT] = exc0 | exc1;
   end

   // ------------------------------------------------------------
   // register read port
   // ------------------------------------------------------------
   logic [31:0] rdata_next;

   always_comb begin
      rdata_next = RDATA_RESET;
      if (reg_addr == OFS_LOOK0) begin
         rdata_next = first_channel_bus;
      end else if (reg_addr == OFS_LOOK1) begin
         rdata_next = second_channel_bus;
      end else if (reg_addr == OFS_LOOKF) begin
         rdata_next = full_res;
      end else if (reg_addr == OFS_CTRL0) begin
         rdata_next = ctrl_view;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_rdata <= RDATA_RESET;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end else begin
         reg_rdata <= RDATA_RESET;
      end
   end

   // ------------------------------------------------------------
   // accumulator write-back
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wb_valid <= 1'b0;
         first_accumulator_load <= RDATA_RESET;
         second_accumulator_load <= RDATA_RESET;
      end else begin
         wb_valid <= advance_read;
         if (advance_read) begin
            first_accumulator_load <= ctrl_reg[XRES_BIT] ? second_channel_res
                                                         : first_channel_res;
            second_accumulator_load <= ctrl1[XRES_BIT] ? first_channel_res
                                                       : second_channel_res;
         end
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_sync_n);

   logic [31:0] lo_mask0;
   assign lo_mask0 = ~(ALL_ONES << ilc_fld5(ctrl_reg, MLSB_LO));

   logic exc0_ref;
   logic [ALPHA_W-1:0] alpha1;
   logic [1:0] force0_sel;
   logic [31:0] full_interpolate_mode_ref;
   logic [31:0] raw0_ref;
   logic [31:0] wb0_ref;
   logic [31:0] wb1_ref;
   assign exc0_ref = |((acc0_sel >> ilc_fld5(ctrl_reg, SHIFT_LO)) &
      ~(ALL_ONES >> (5'd31 - ilc_fld5(ctrl_reg, MMSB_LO))));
   assign alpha1 = sm1[ALPHA_W-1:0];
   assign force0_sel = ctrl_reg[FORCE_LO+:2];
   assign full_interpolate_mode_ref = third_offset + sm0_ext;
   assign raw0_ref = ilc_force(first_offset + acc0_sel, ctrl_reg);
   assign wb0_ref = ctrl_reg[XRES_BIT] ? second_channel_res : first_channel_res;
   assign wb1_ref = ctrl1[XRES_BIT] ? first_channel_res : second_channel_res;

   property p_look0;
      reg_rd && reg_addr == OFS_LOOK0 |=> reg_rdata == $past(first_channel_bus);
   endproperty
   a_look0: assert property (p_look0)
      else $error("first-channel look data wrong");

   property p_look_quiet;
      reg_rd && !reg_wr && !advance_read |=>
         ctrl_reg == $past(ctrl_reg) && !wb_valid;
   endproperty
   a_look_quiet: assert property (p_look_quiet)
      else $error("look read changed internal state");

   property p_look1;
      reg_rd && reg_addr == OFS_LOOK1 |=> reg_rdata == $past(second_channel_bus);
   endproperty
   a_look1: assert property (p_look1)
      else $error("second-channel look data wrong");

   property p_lookf;
      reg_rd && reg_addr == OFS_LOOKF |=> reg_rdata == $past(full_res);
   endproperty
   a_lookf: assert property (p_lookf)
      else $error("combined look data wrong");

   property p_exc0;
      reg_rd && reg_addr == OFS_CTRL0 |=>
         reg_rdata[EXC0_BIT] == $past(exc0_ref);
   endproperty
   a_exc0: assert property (p_exc0)
      else $error("first excess flag wrong");

   property p_exc1;
      reg_rd && reg_addr == OFS_CTRL0 |=> reg_rdata[EXC1_BIT] == $past(exc1);
   endproperty
   a_exc1: assert property (p_exc1)
      else $error("second excess flag wrong");

   property p_exca;
      reg_rd && reg_addr == OFS_CTRL0 |=>
         reg_rdata[EXCA_BIT] == (reg_rdata[EXC0_BIT] | reg_rdata[EXC1_BIT]);
   endproperty
   a_exca: assert property (p_exca)
      else $error("combined excess flag wrong");

   property p_blend0;
      reg_rd && reg_addr == OFS_LOOK0 && interpolate_mode |=>
         reg_rdata[27:8] == 20'h0_0000 &&
         reg_rdata[7:0] == $past(alpha1);
   endproperty
   a_blend0: assert property (p_blend0)
      else $error("interpolate first_channel result wrong");

   property p_blendf;
      reg_rd && reg_addr == OFS_LOOKF && interpolate_mode |=>
         reg_rdata == $past(full_interpolate_mode_ref);
   endproperty
   a_blendf: assert property (p_blendf)
      else $error("interpolate combined result wrong");

   property p_force;
      reg_rd && reg_addr == OFS_LOOK0 |=>
         (reg_rdata[29:28] & $past(force0_sel)) == $past(force0_sel);
   endproperty
   a_force: assert property (p_force)
      else $error("forced top bits missing");

   property p_wb;
      advance_read |=> wb_valid && first_accumulator_load ==
         $past(wb0_ref);
   endproperty
   a_wb: assert property (p_wb)
      else $error("accumulator write-back wrong");

   property p_mask;
      !interpolate_mode && !ctrl_reg[RAW_BIT] |-> (sm0 & lo_mask0) == 32'h0000_0000;
   endproperty
   a_mask: assert property (p_mask)
      else $error("mask passed bits below low index");

   property p_raw0;
      reg_rd && reg_addr == OFS_LOOK0 && !interpolate_mode && ctrl_reg[RAW_BIT] |=>
         reg_rdata == $past(raw0_ref);
   endproperty
   a_raw0: assert property (p_raw0)
      else $error("raw first_channel result wrong");

   property p_wb1;
      advance_read |=> second_accumulator_load == $past(wb1_ref);
   endproperty
   a_wb1: assert property (p_wb1)
      else $error("second accumulator write-back wrong");

   property p_no_interpolate_mode;
      !FIRST_INSTANCE |-> !ctrl_reg[INTERPOLATE_MODE_BIT];
   endproperty
   a_no_interpolate_mode: assert property (p_no_interpolate_mode)
      else $error("interpolate bit stored in second instance");

   property p_sext0;
      ctrl_reg[SIGNED_BIT] && sm0[ilc_fld5(ctrl_reg, MMSB_LO)] |->
         sm0_ext[31];
   endproperty
   a_sext0: assert property (p_sext0)
      else $error("first_channel sign extension missing");

   c_interpolate_mode_look: cover property (reg_rd && reg_addr == OFS_LOOK1 && interpolate_mode);
   c_cross_pop: cover property (advance_read && ctrl_reg[XRES_BIT]);
   c_excess: cover property (reg_rd && reg_addr == OFS_CTRL0 && exc0);
   c_raw_look: cover property (reg_rd && reg_addr == OFS_LOOK0 &&
      ctrl_reg[RAW_BIT]);
endmodule // ilc_top

// [testbench/ilc_top_tb.sv]
// self-checking bench for the interpolator lane-zero block
`timescale 1ns/10ps
module ilc_top_tb;
   import ilc_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam int LIMIT = 2000;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, rdata_nb;
   logic [31:0] first_accumulator = '0, second_accumulator = '0;
   logic [31:0] first_offset = '0, second_offset = '0, third_offset = '0;
   logic [31:0] second_channel_control = '0;
   logic advance_read = 1'b0;
   logic wb_valid;
   logic [31:0] first_accumulator_load, second_accumulator_load;
   logic [31:0] ctrl_w, e_l0, e_l1, e_fl, e_ctl, e_ctl2, e_ld0, e_ld1;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;

   always #25 core_clk = ~core_clk;

   ilc_top #(.FIRST_INSTANCE(1'b1)) uut (.core_clk(core_clk),
      .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .first_accumulator(first_accumulator),
      .second_accumulator(second_accumulator),
      .first_offset(first_offset), .second_offset(second_offset),
      .third_offset(third_offset),
      .second_channel_control(second_channel_control),
      .advance_read(advance_read), .wb_valid(wb_valid),
      .first_accumulator_load(first_accumulator_load),
      .second_accumulator_load(second_accumulator_load));

   // second instance without interpolate mode
   ilc_top #(.FIRST_INSTANCE(1'b0)) uut_nb (.core_clk(core_clk),
      .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_nb),
      .first_accumulator(first_accumulator),
      .second_accumulator(second_accumulator),
      .first_offset(first_offset), .second_offset(second_offset),
      .third_offset(third_offset),
      .second_channel_control(second_channel_control),
      .advance_read(advance_read), .wb_valid(),
      .first_accumulator_load(), .second_accumulator_load());

   // ------------------------------------------------------------
   // reporting
   // ------------------------------------------------------------
   task automatic close_out();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         mismatches++;
         close_out();
      end
   end

   // ------------------------------------------------------------
   // reference model
   // ------------------------------------------------------------
   function automatic logic [31:0] sm_of(input logic [31:0] acc,
                                         input logic [31:0] c,
                                         output logic exc);
      logic [31:0] s, hi, r;
      s = acc >> c[4:0];
      hi = ALL_ONES >> (5'd31 - c[14:10]);
      exc = |(s & ~hi);
      r = s & hi & (ALL_ONES << c[9:5]);
      if (c[15] && r[c[14:10]]) begin
         r = r | ~hi;
      end
      return r;
   endfunction

   task automatic model();
      logic [31:0] in0, in1, s0, s1, c1;
      logic [39:0] d, p;
      logic x0, x1;
      c1 = second_channel_control;
      in0 = ctrl_w[16] ? second_accumulator : first_accumulator;
      in1 = c1[16] ? first_accumulator : second_accumulator;
      s0 = sm_of(in0, ctrl_w, x0);
      s1 = sm_of(in1, c1, x1);
      if (ctrl_w[21]) begin
         if (c1[15]) begin
            d = {{8{second_offset[31]}}, second_offset} -
                {{8{first_offset[31]}}, first_offset};
         end else begin
            d = {8'h00, second_offset} - {8'h00, first_offset};
         end
         p = d * {32'h0, s1[7:0]};
         e_l1 = first_offset + p[39:8];
         e_l0 = {24'h0, s1[7:0]};
         e_fl = third_offset + s0;
      end else begin
         e_l0 = first_offset + (ctrl_w[18] ? in0 : s0);
         e_l1 = second_offset + (c1[18] ? in1 : s1);
         e_fl = third_offset + s0 + s1;
      end
      e_ld0 = ctrl_w[17] ? e_l1 : e_l0;
      e_ld1 = c1[17] ? e_l0 : e_l1;
      e_ctl = (ctrl_w & CTRL_WR_MASK) | {6'h0, x0 | x1, x1, x0, 23'h0};
      e_ctl2 = (ctrl_w & CTRL_WR_MASK_NB) | {6'h0, x0 | x1, x1, x0, 23'h0};
      e_l0 = e_l0 | {2'b00, ctrl_w[20:19], 28'h0};
      e_l1 = e_l1 | {2'b00, c1[20:19], 28'h0};
   endtask

   // ------------------------------------------------------------
   // bus and advance tasks
   // ------------------------------------------------------------
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e,
                     input logic [31:0] e2);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
      if (a == OFS_CTRL0) begin
         chk(rdata_nb, e2);
      end
      chk({31'h0, wb_valid}, 32'h0);
      @(posedge core_clk);
      #1;
      chk(reg_rdata, 32'h0);
   endtask

   task automatic adv();
      @(posedge core_clk);
      advance_read <= 1'b1;
      @(posedge core_clk);
      advance_read <= 1'b0;
      #1;
      chk({31'h0, wb_valid}, 32'h1);
      chk(first_accumulator_load, e_ld0);
      chk(second_accumulator_load, e_ld1);
      @(posedge core_clk);
      #1;
      chk({31'h0, wb_valid}, 32'h0);
      chk(first_accumulator_load, e_ld0);
   endtask

   // one setting: mask high index never below low index
   task automatic run_case(input logic [31:0] c0, input logic [31:0] c1,
                           input logic [31:0] a0, input logic [31:0] a1,
                           input logic [31:0] b0, input logic [31:0] b1,
                           input logic [31:0] b2);
      @(posedge core_clk);
      second_channel_control <= c1;
      first_accumulator <= a0;
      second_accumulator <= a1;
      first_offset <= b0;
      second_offset <= b1;
      third_offset <= b2;
      wr(OFS_CTRL0, c0 | 32'hFFC0_0000);
      ctrl_w = c0;
      model();
      rd(OFS_LOOK0, e_l0, 32'h0);
      rd(OFS_LOOK1, e_l1, 32'h0);
      rd(OFS_LOOKF, e_fl, 32'h0);
      rd(OFS_CTRL0, e_ctl, e_ctl2);
      adv();
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(OFS_LOOK0, 32'h0, 32'h0);
      rd(OFS_LOOK1, 32'h0, 32'h0);
      rd(OFS_LOOKF, 32'h0, 32'h0);
      rd(OFS_CTRL0, CTRL_RESET, CTRL_RESET);
      rd(12'h0B0, 32'h0, 32'h0);
      run_case(32'h0000_2444, 32'h0000_3C00, 32'hF123_4567, 32'h0000_1234,
               32'h0000_1000, 32'h0000_2000, 32'h0000_3000);
      run_case(32'h0000_9C00, 32'h0000_3C00, 32'h0000_00F0, 32'h0000_0005,
               32'h0000_1000, 32'h0000_2000, 32'h0000_3000);
      run_case(32'h0005_0C08, 32'h0000_3C00, 32'h0000_0001, 32'h0000_ABCD,
               32'h0000_1000, 32'h0000_2000, 32'h0000_3000);
      run_case(32'h0018_3C00, 32'h0008_3C00, 32'h0000_0011, 32'h0000_0022,
               32'h0000_1000, 32'h0000_2000, 32'h0000_3000);
      run_case(32'h0020_3C00, 32'h0000_1C00, 32'h0000_0033, 32'h0000_0040,
               32'h0000_0100, 32'h0000_0300, 32'h0000_0050);
      run_case(32'h0020_3C00, 32'h0000_9C00, 32'h0000_0033, 32'h0000_00C0,
               32'h0000_0400, 32'h0000_0100, 32'h0000_0050);
      run_case(32'h0020_3C00, 32'h0000_1C00, 32'h0000_0033, 32'h0000_0080,
               32'h0000_0400, 32'h0000_0100, 32'h0000_0050);
      run_case(32'h0002_3C00, 32'h0002_3C00, 32'h0000_0007, 32'h0000_0009,
               32'h0000_1000, 32'h0000_2000, 32'h0000_3000);
      run_case(32'h0000_3C00, 32'h0000_0C00, 32'h0000_0007, 32'h0000_0100,
               32'h0000_1000, 32'h0000_2000, 32'h0000_3000);
      wr(OFS_LOOK0, 32'h0000_1FFF);
      rd(OFS_CTRL0, e_ctl, e_ctl2);
      close_out();
   end
endmodule // ilc_top_tb
